//--- pkg/mic_pkg.sv
/*
 * Constants and types shared by the microphone converter reader.
 * Assumes a single system clock at SYS_CLK_HZ feeding every file.
 */
`default_nettype none

package mic_pkg;

    // System and serial clock rates
    localparam int unsigned SYS_CLK_HZ = 250_000_000;
    localparam int unsigned SCLK_HZ = 12_500_000;
    // System cycles per serial clock half period
    localparam int unsigned SCLK_HALF_INT = SYS_CLK_HZ / (2 * SCLK_HZ);
    localparam logic [4:0] SCLK_HALF_CYC = 5'(SCLK_HALF_INT);

    // Frame layout
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned RESULT_BITS = 12;
    localparam int unsigned RESULT_LSB = 0;
    localparam logic [4:0] FRAME_LAST_BIT = 5'h0F;

    // Reset values
    localparam logic SCLK_IDLE = 1'b1;
    localparam logic SEL_IDLE = 1'b1;
    localparam logic DONE_RST = 1'b1;
    localparam logic [15:0] FRAME_RST = 16'h0000;
    localparam logic [11:0] RESULT_RST = 12'h000;
    localparam logic [4:0] COUNT_RST = 5'h00;

    typedef enum logic [1:0]
    {
        IDLE_STATE,
        BIT_CAPTURE_STATE,
        RESULT_PUBLISH_STATE
    } mic_state_t;

endpackage

`default_nettype wire

//--- rtl/mic_pair_buf.sv
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes the filler watches in_ready_o and the drainer may stall.
 */
`default_nettype none

module mic_pair_buf
    import mic_pkg::*;
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    input wire logic [11:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [11:0] out_data_o,
    input wire logic out_ready_i
);

    typedef struct packed
    {
        logic head_valid;
        logic [11:0] head_data;
        logic tail_valid;
        logic [11:0] tail_data;
    } mic_buf_t;

    mic_buf_t r;
    mic_buf_t next_r;
    logic push;
    logic pop;

    assign in_ready_o = !r.tail_valid;
    assign out_valid_o = r.head_valid;
    assign out_data_o = r.head_data;
    assign push = in_valid_i && !r.tail_valid;
    assign pop = r.head_valid && out_ready_i;

    always_comb
    begin
        next_r = r;
        if (pop)
        begin
            if (r.tail_valid)
            begin
                next_r.head_data = r.tail_data;
                next_r.tail_valid = 1'b0;
            end
            else if (push)
            begin
                next_r.head_data = in_data_i;
            end
            else
            begin
                next_r.head_valid = 1'b0;
            end
        end
        else if (push)
        begin
            if (!r.head_valid)
            begin
                next_r.head_valid = 1'b1;
                next_r.head_data = in_data_i;
            end
            else
            begin
                next_r.tail_valid = 1'b1;
                next_r.tail_data = in_data_i;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

endmodule

`default_nettype wire

//--- rtl/mic_reader_top.sv
/*
 * Reader for a serial 12-bit converter: makes serial clock and select,
 * shifts in a 16-bit frame and publishes the low twelve bits.
 * Each result is also offered on a valid/ready stream through a
 * two-entry buffer, so a stalling receiver loses no word.
 * Assumes start_i and conv_serial_in_i are synchronous to clock_i,
 * and that the converter changes its data on falling serial clock.
 */
`default_nettype none

// Overview of operation
// - One system clock, asynchronous reset, converter serial data input.
// - Serial clock at 12.5MHz is divided from system clock during frames.
// - Select held low while converter shifts bits out on falling edges.
// - Select driven high right after the last bit arrives.
// - Exactly three states: idle, bit capture, result publish.
// - Done output is high while idle.
// - Start high while idle moves the machine into bit capture.
// - Bit capture drives done low, shifts sixteen bits MSB first.
// - After all frame bits, move from capture to result publish.
// - Result publish places twelve result bits on the data output.
// - Publish returns to idle only once start is low.
// - Reset forces idle at once from any state.
module mic_reader_top
    import mic_pkg::*;
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic conv_serial_in_i,
    input wire logic res_ready_i,
    output logic conv_sclk_o,
    output logic conv_select_n_o,
    output logic done_o,
    output logic [11:0] data_o,
    output logic res_valid_o,
    output logic [11:0] res_data_o
);

    typedef struct packed
    {
        mic_state_t state;
        logic [4:0] div;
        logic [4:0] bits;
        logic sclk;
        logic sel_n;
        logic done;
        logic pushed;
        logic [15:0] frame;
        logic [11:0] data;
    } mic_regs_t;

    mic_regs_t r;
    mic_regs_t next_r;
    logic buf_in_valid;
    logic buf_in_ready;
    logic half_end;
    logic rise_edge;
    logic frame_end;

    // Last cycle of a serial clock half period
    function automatic logic half_done(input logic [4:0] cnt);
        half_done = (cnt == 5'(SCLK_HALF_CYC - 5'h01));
    endfunction

    // Result field of a captured frame
    function automatic logic [11:0] frame_result(input logic [15:0] f);
        frame_result = f[RESULT_LSB +: RESULT_BITS];
    endfunction

    // Counter step
    function automatic logic [4:0] count_up(input logic [4:0] cnt);
        count_up = 5'(cnt + 5'h01);
    endfunction

    // Frame with one more bit at the bottom
    function automatic logic [15:0] shift_in(input logic [15:0] f,
        input logic b);
        shift_in = {f[14:0], b};
    endfunction

    // Converter link parked
    function automatic mic_regs_t park_link(input mic_regs_t s);
        mic_regs_t p;
        p = s;
        p.sel_n = SEL_IDLE;
        p.sclk = SCLK_IDLE;
        park_link = p;
    endfunction

    // Serial clock edge decode
    assign half_end = half_done(r.div);
    assign rise_edge = half_end && !r.sclk;
    assign frame_end = rise_edge && (r.bits == FRAME_LAST_BIT);

    // Publish offers its result once
    assign buf_in_valid = (r.state == RESULT_PUBLISH_STATE) && !r.pushed;

    // Next state and outputs
    always_comb
    begin
        next_r = r;
        case (r.state)
            IDLE_STATE:
            begin
                next_r.done = 1'b1;
                next_r = park_link(next_r);
                next_r.div = COUNT_RST;
                next_r.bits = COUNT_RST;
                if (start_i)
                begin
                    next_r.state = BIT_CAPTURE_STATE;
                    next_r.done = 1'b0;
                    next_r.sel_n = 1'b0;
                    next_r.pushed = 1'b0;
                end
            end
            BIT_CAPTURE_STATE:
            begin
                next_r.done = 1'b0;
                if (half_end)
                begin
                    next_r.div = COUNT_RST;
                    next_r.sclk = !r.sclk;
                end
                else
                begin
                    next_r.div = count_up(r.div);
                end
                if (rise_edge)
                begin
                    next_r.frame = shift_in(r.frame, conv_serial_in_i);
                    next_r.bits = count_up(r.bits);
                end
                if (frame_end)
                begin
                    next_r.state = RESULT_PUBLISH_STATE;
                    next_r = park_link(next_r);
                    next_r.data = frame_result(
                        shift_in(r.frame, conv_serial_in_i));
                    next_r.done = 1'b1;
                end
            end
            RESULT_PUBLISH_STATE:
            begin
                next_r.done = 1'b1;
                next_r = park_link(next_r);
                if (buf_in_ready && !r.pushed)
                begin
                    next_r.pushed = 1'b1;
                end
                if ((r.pushed || buf_in_ready) && !start_i)
                begin
                    next_r.state = IDLE_STATE;
                end
            end
            default:
            begin
                next_r.state = IDLE_STATE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            r.state <= IDLE_STATE;
            r.div <= COUNT_RST;
            r.bits <= COUNT_RST;
            r.sclk <= SCLK_IDLE;
            r.sel_n <= SEL_IDLE;
            r.done <= DONE_RST;
            r.pushed <= 1'b0;
            r.frame <= FRAME_RST;
            r.data <= RESULT_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign data_o = r.data;
    assign done_o = r.done;
    assign conv_sclk_o = r.sclk;
    assign conv_select_n_o = r.sel_n;

    // Result stream toward user logic
    mic_pair_buf i_mic_pair_buf
    (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .in_valid_i(buf_in_valid),
        .in_data_i(r.data),
        .in_ready_o(buf_in_ready),
        .out_valid_o(res_valid_o),
        .out_data_o(res_data_o),
        .out_ready_i(res_ready_i)
    );

endmodule

`default_nettype wire

//--- tb/mic_adc_model.sv
/* Behavioural serial converter for the reader bench.
   Assumes sclk and select come from the reader under test. */
`default_nettype none
module mic_conv_model
(
    input wire logic sclk_i,
    input wire logic sel_n_i,
    input wire logic [15:0] word_i,
    output logic sdo_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int idx;
    initial
    begin
        sdo_o = 1'b0;
        idx = 15;
    end
    always @(negedge sel_n_i) idx = 15;
    always @(negedge sclk_i)
    begin
        if (!sel_n_i && idx >= 0)
        begin
            sdo_o = word_i[idx];
            idx--;
        end
    end
    // Released line shows inverse
    always @(posedge sel_n_i) sdo_o = ~sdo_o;
endmodule
`default_nettype wire

//--- tb/mic_reader_props.sv
/* Port checker for the converter reader.
   Assumes binding to every reader top instance. */
`default_nettype none
module mic_reader_props
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic res_ready_i,
    input wire logic conv_sclk_o,
    input wire logic conv_select_n_o,
    input wire logic done_o,
    input wire logic [11:0] data_o,
    input wire logic res_valid_o,
    input wire logic [11:0] res_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] low_cnt;
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            low_cnt <= 9'h000;
        else if (conv_select_n_o)
            low_cnt <= 9'h000;
        else
            low_cnt <= low_cnt + 9'h001;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    chk_sclk_idle_high: assert property (
        conv_select_n_o |-> conv_sclk_o)
        else $error("sclk low while deselected");
    chk_done_low_capture: assert property (
        !conv_select_n_o |-> !done_o)
        else $error("done high during capture");
    chk_done_high_idle: assert property (
        conv_select_n_o |-> done_o)
        else $error("done low outside capture");
    chk_start_begins: assert property (
        $fell(conv_select_n_o) |-> $past(start_i))
        else $error("frame began without start");
    chk_frame_length: assert property (
        $rose(conv_select_n_o) |-> low_cnt == 9'h140)
        else $error("select low time wrong");
    chk_sclk_half: assert property (
        $fell(conv_sclk_o) |-> (!conv_sclk_o)[*5] ##1
        (!conv_sclk_o)[*5] ##1 conv_sclk_o)
        else $error("sclk low half period wrong");
    chk_sclk_high_half: assert property (
        $rose(conv_sclk_o) && !conv_select_n_o |-> conv_sclk_o[*5] ##1
        conv_sclk_o[*5] ##1 !conv_sclk_o)
        else $error("sclk high half period wrong");
    chk_data_holds: assert property (
        $changed(data_o) |-> $rose(conv_select_n_o))
        else $error("data changed outside publish");
    chk_word_pushed: assert property (
        $rose(conv_select_n_o) && !res_valid_o |->
        ##1 res_valid_o && res_data_o == data_o)
        else $error("result not offered");
    chk_res_stall: assert property (
        res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_data_o))
        else $error("result lost in stall");
endmodule
bind mic_reader_top mic_reader_props i_mic_reader_props(.clock_i(clock_i),
    .rstn_i(rstn_i), .start_i(start_i), .res_ready_i(res_ready_i),
    .conv_sclk_o(conv_sclk_o), .conv_select_n_o(conv_select_n_o),
    .done_o(done_o), .data_o(data_o), .res_valid_o(res_valid_o),
    .res_data_o(res_data_o));
`default_nettype wire

//--- tb/mic_adc_serial_reader_bench.sv
/* Self-checking bench for the converter reader.
   Assumes the converter model and the port checker. */
`default_nettype none
module mic_adc_serial_reader_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0, rstn_i = 1'b0, start_i = 1'b0, res_ready_i = 1'b0;
    logic sdi, sclk, sel_n, done, rvalid;
    logic [11:0] data, rdata;
    logic [15:0] word = 16'h0000;
    int n_fail = 0, checks = 0;
    always #2 clock_i = ~clock_i;
    mic_reader_top i_mic_reader_top(.clock_i(clock_i), .rstn_i(rstn_i),
        .start_i(start_i), .conv_serial_in_i(sdi), .res_ready_i(res_ready_i),
        .conv_sclk_o(sclk), .conv_select_n_o(sel_n), .done_o(done),
        .data_o(data), .res_valid_o(rvalid), .res_data_o(rdata));
    mic_conv_model i_mic_conv_model(.sclk_i(sclk), .sel_n_i(sel_n),
        .word_i(word), .sdo_o(sdi));
    task automatic stop_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_sel(input logic lvl);
        int k;
        k = 0;
        while (sel_n !== lvl && k < 500)
        begin
            @(negedge clock_i);
            k++;
        end
        if (k >= 500)
        begin
            n_fail++;
            stop_test();
        end
    endtask
    task automatic convert(input logic [15:0] w);
        word = w;
        @(negedge clock_i);
        start_i = 1'b1;
        wait_sel(1'b0);
        wait_sel(1'b1);
    endtask
    task automatic pop(input logic [11:0] exp);
        int k;
        k = 0;
        while (rvalid !== 1'b1 && k < 50)
        begin
            @(negedge clock_i);
            k++;
        end
        if (k >= 50)
        begin
            n_fail++;
            stop_test();
        end
        chk({4'h0, rdata}, {4'h0, exp});
        res_ready_i = 1'b1;
        @(negedge clock_i);
        res_ready_i = 1'b0;
        @(negedge clock_i);
    endtask
    task automatic t_basic();
        convert(16'hA5C3);
        start_i = 1'b0;
        chk({4'h0, data}, 16'h05C3);
        chk({14'h0000, sel_n, done}, 16'h0003);
        pop(12'h5C3);
        $display("test basic done");
    endtask
    task automatic t_hold();
        convert(16'h3FFF);
        repeat (40) @(negedge clock_i);
        chk({15'h0000, sel_n}, 16'h0001);
        chk({4'h0, data}, 16'h0FFF);
        start_i = 1'b0;
        pop(12'hFFF);
        $display("test hold done");
    endtask
    task automatic t_stall();
        convert(16'hF001);
        start_i = 1'b0;
        convert(16'h0ABC);
        start_i = 1'b0;
        convert(16'h7123);
        start_i = 1'b0;
        repeat (20) @(negedge clock_i);
        pop(12'h001);
        pop(12'hABC);
        pop(12'h123);
        $display("test stall done");
    endtask
    task automatic t_reset();
        word = 16'h1234;
        @(negedge clock_i);
        start_i = 1'b1;
        repeat (100) @(negedge clock_i);
        rstn_i = 1'b0;
        #1;
        chk({13'h0000, sel_n, sclk, done}, 16'h0007);
        chk({4'h0, data}, 16'h0000);
        @(negedge clock_i);
        start_i = 1'b0;
        rstn_i = 1'b1;
        convert(16'h0C0F);
        start_i = 1'b0;
        chk({4'h0, data}, 16'h0C0F);
        $display("test reset done");
    endtask
    initial
    begin
        repeat (2) @(negedge clock_i);
        rstn_i = 1'b1;
        t_basic();
        t_hold();
        t_stall();
        t_reset();
        stop_test();
    end
endmodule
`default_nettype wire
